// [inc/fz_defines.svh]
`ifndef FZ_DEFINES_SVH
`define FZ_DEFINES_SVH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define FZ_A_REPORT   8'h00
`define FZ_A_CEIL1    8'h38
`define FZ_A_CEIL2    8'h39
`define FZ_A_CEIL3    8'h3a
`define FZ_A_LIM4     8'h3b
`define FZ_A_R3C      8'h3c
`define FZ_A_CFG1     8'h5c
`define FZ_A_CFG2     8'h5d
`define FZ_A_CFG3     8'h5e
`define FZ_A_R62      8'h62
`define FZ_A_R63      8'h63
`define FZ_A_FLOOR1   8'h64
`define FZ_A_FLOOR2   8'h65
`define FZ_A_FLOOR3   8'h66
`define FZ_A_LIM1     8'h67
`define FZ_A_LIM2     8'h68
`define FZ_A_LIM3     8'h69
// ----------------------------------------
// reset values
// ----------------------------------------
`define FZ_RST_CEIL   8'hff
`define FZ_RST_FLOOR  8'h80
`define FZ_RST_LIM    8'h5a
`define FZ_RST_LIM4   8'he0
`define FZ_RST_R3C    8'hc3
`define FZ_RST_R62    8'h00
`define FZ_RST_R63    8'h00
`define FZ_RST_CFG    8'h62
`define FZ_ABS_OFF    8'h80
`define FZ_DUTY_FULL  8'hff
`define FZ_PWM_TOP    8'hfe
// ----------------------------------------
// timing
// ----------------------------------------
`define FZ_CLK_KHZ    25000
`define FZ_TICK_MS    1
`define FZ_TICK_CYC   (`FZ_CLK_KHZ * `FZ_TICK_MS)
`define FZ_SPIN_MS0   12'd0
`define FZ_SPIN_MS1   12'd100
`define FZ_SPIN_MS2   12'd250
`define FZ_SPIN_MS3   12'd400
`define FZ_SPIN_MS4   12'd700
`define FZ_SPIN_MS5   12'd1000
`define FZ_SPIN_MS6   12'd2000
`define FZ_SPIN_MS7   12'd4000
// smoothing step time in tenths of a second
`define FZ_SM_DS0     350
`define FZ_SM_DS1     176
`define FZ_SM_DS2     118
`define FZ_SM_DS3     70
`define FZ_SM_DS4     44
`define FZ_SM_DS5     30
`define FZ_SM_DS6     16
`define FZ_SM_DS7     8
// filter updates per step time, and shift of the averager
`define FZ_SM_STEPS   16
`define FZ_SM_SHIFT   2
`endif

// [inc/fz_pkg.sv]
package fz_pkg;
    typedef logic signed [7:0] fz_temp_t;
    typedef enum logic [2:0] {
        FZ_M_Z1, FZ_M_Z2, FZ_M_Z3, FZ_M_FULL,
        FZ_M_OFF, FZ_M_HOT23, FZ_M_HOT123, FZ_M_MANUAL
    } fz_mode_t;
    typedef struct packed {
        fz_mode_t    mode;
        logic        pwm_polarity_invert;
        logic        alt;
        logic [2:0]  spin;
    } fz_fan_cfg_t;
    typedef struct packed {
        logic signed [15:0] acc;
        logic [15:0]        cnt;
    } fz_smooth_t;
    typedef struct packed {
        fz_fan_cfg_t [2:0]   cfg;
        logic [2:0][7:0]     ceil;
        logic [2:0][7:0]     floor;
        logic [3:0][7:0]     lim;
        logic [7:0]          r62;
        logic [7:0]          r63;
        logic [7:0]          r3c;
        logic [2:0][7:0]     duty;
        logic [2:0][11:0]    spin_cnt;
        logic [2:0]          running;
        logic [3:0]          over;
        logic [7:0]          report;
        logic [7:0]          pwm_cnt;
        logic [15:0]         tick_cnt;
        logic                tick;
        logic [7:0]          rdata;
        logic [2:0]          pwm;
    } fz_state_t;
endpackage

// [logic/fz_smoother.sv]
`timescale 1ns/1ps
`include "fz_defines.svh"
module fz_smoother
    import fz_pkg::*;
(
    input  wire logic       core_clk_in,
    input  wire logic       nrst_in,
    input  wire logic       tick_in,
    input  wire logic       en_in,
    input  wire logic [2:0] sel_in,
    input  wire fz_temp_t   temp_in,
    output fz_temp_t        temp_out
);
    fz_smooth_t       s;
    fz_smooth_t       next_s;
    logic [15:0]      interval;
    logic signed [15:0] target;

    // ----------------------------------------
    // update interval in ms per step time
    // ----------------------------------------
    always_comb begin
        unique case (sel_in)
            3'd0: interval = 16'(`FZ_SM_DS0 * 100 / `FZ_SM_STEPS);
            3'd1: interval = 16'(`FZ_SM_DS1 * 100 / `FZ_SM_STEPS);
            3'd2: interval = 16'(`FZ_SM_DS2 * 100 / `FZ_SM_STEPS);
            3'd3: interval = 16'(`FZ_SM_DS3 * 100 / `FZ_SM_STEPS);
            3'd4: interval = 16'(`FZ_SM_DS4 * 100 / `FZ_SM_STEPS);
            3'd5: interval = 16'(`FZ_SM_DS5 * 100 / `FZ_SM_STEPS);
            3'd6: interval = 16'(`FZ_SM_DS6 * 100 / `FZ_SM_STEPS);
            3'd7: interval = 16'(`FZ_SM_DS7 * 100 / `FZ_SM_STEPS);
        endcase
    end

    // ----------------------------------------
    // first-order recursive averager
    // ----------------------------------------
    always_comb begin
        next_s = s;
        target = {temp_in, 8'h00};
        if (!en_in) begin
            next_s.acc = target;
            next_s.cnt = 16'h0000;
        end else if (tick_in) begin
            if (s.cnt + 16'h0001 >= interval) begin
                next_s.cnt = 16'h0000;
                next_s.acc = s.acc + ((target - s.acc) >>> `FZ_SM_SHIFT);
            end else begin
                next_s.cnt = s.cnt + 16'h0001;
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign temp_out = s.acc[15:8];
endmodule // fz_smoother

// [logic/fz_fan_ctrl.sv]
`timescale 1ns/1ps
`include "fz_defines.svh"
// What this block does
// - invert clear holds full duty output high; invert set holds it low.
// - a fan starting from standstill runs full duty for the spin-up time.
// - three-bit spin-up field selects 0 to 4000 ms.
// - read-only report at offset zero: fan 3, 2, 1 zones high to low.
// - zone codes 1=01, 2=10, 3=11, 4=00; hottest modes show chosen zone.
// - fixed zone or manual control reports 00.
// - writes to the report register are ignored.
// - below the limit duty is zero, or the minimum when floor-select is set.
// - each zone has its own smoothing enable bit.
// - three-bit field sets smoothing step time, 35 s down to 0.8 s.
// - readings keep first-filter values; second filter feeds fan control.
// - minimum duty applies at the limit; resets to 80h.
// - automatic duty exceeds the ceiling register, reset FFh, only under the absolute-maximum override.
// - above the chosen zone's absolute maximum the ceiling is overridden to full duty.
// - override ends once temperature falls below the limit minus the hysteresis, or when the limit is set to 80h.
// - fan turns on at the limit and ramps above it.
// - limits are signed degrees; zones 1-3 reset 5Ah, zone 4 E0h.
// - lock makes all these configuration registers read-only.
// - duty scales linearly, 00h is 0 percent and FFh 100 percent.
// - hottest-of picks the zone with larger computed duty.
// - absolute limit 80h disables the override.
module fz_fan_ctrl
    import fz_pkg::*;
#(
    parameter int          TICK_CYCLES = `FZ_TICK_CYC,
    parameter logic [7:0]  RAMP_STEP   = 8'h10
)(
    input  wire logic            core_clk_in,
    input  wire logic            nrst_in,
    input  wire logic [7:0]      reg_addr_in,
    input  wire logic            reg_wr_in,
    input  wire logic [7:0]      reg_wdata_in,
    input  wire logic            lock_in,
    input  wire fz_temp_t [3:0]  zone_temp_in,
    input  wire fz_temp_t [3:0]  zone_abs_limit_in,
    input  wire logic [3:0][3:0] zone_hyst_in,
    input  wire logic [2:0][7:0] manual_duty_in,
    output logic [7:0]           reg_rdata_out,
    output logic [2:0]           pwm_out,
    output logic [2:0][7:0]      fan_duty_out,
    output fz_temp_t [3:0]       zone_ctrl_temp_out
);
    fz_state_t          st;
    fz_state_t          next_st;
    fz_temp_t [3:0]     ztemp;
    logic [3:0]         sm_en;
    logic [3:0][2:0]    sm_sel;
    logic [2:0]         floor_sel;

    // ----------------------------------------
    // smoothing field decode
    // ----------------------------------------
    assign floor_sel = st.r62[7:5];
    assign sm_en     = {st.r3c[3], st.r63[3], st.r63[7], st.r62[3]};
    assign sm_sel    = {st.r3c[2:0], st.r63[2:0], st.r63[6:4], st.r62[2:0]};

    // ----------------------------------------
    // second filter per zone
    // ----------------------------------------
    for (genvar z = 0; z < 4; z++) begin : g_zone
        fz_smoother u_sm (
            .core_clk_in (core_clk_in),
            .nrst_in     (nrst_in),
            .tick_in     (st.tick),
            .en_in       (sm_en[z]),
            .sel_in      (sm_sel[z]),
            .temp_in     (zone_temp_in[z]),
            .temp_out    (ztemp[z])
        );
    end

    // ----------------------------------------
    // linear duty for one zone
    // ----------------------------------------
    function automatic logic [7:0] zone_duty(
        input fz_temp_t   t,
        input fz_temp_t   lim,
        input logic [7:0] fl,
        input logic       fsel
    );
        logic signed [8:0] diff;
        logic [16:0]       prod;
        logic [17:0]       sum;
        diff = 9'(t) - 9'(lim);
        prod = 17'(diff[7:0]) * 17'(RAMP_STEP);
        sum  = 18'(prod) + 18'(fl);
        if (diff < 0) begin
            zone_duty = fsel ? fl : 8'h00;
        end else if (sum > 18'(`FZ_DUTY_FULL)) begin
            zone_duty = `FZ_DUTY_FULL;
        end else begin
            zone_duty = sum[7:0];
        end
    endfunction

    function automatic logic [11:0] spin_ms(input logic [2:0] sel);
        unique case (sel)
            3'd0: spin_ms = `FZ_SPIN_MS0;
            3'd1: spin_ms = `FZ_SPIN_MS1;
            3'd2: spin_ms = `FZ_SPIN_MS2;
            3'd3: spin_ms = `FZ_SPIN_MS3;
            3'd4: spin_ms = `FZ_SPIN_MS4;
            3'd5: spin_ms = `FZ_SPIN_MS5;
            3'd6: spin_ms = `FZ_SPIN_MS6;
            3'd7: spin_ms = `FZ_SPIN_MS7;
        endcase
    endfunction

    // ----------------------------------------
    // next state
    // ----------------------------------------
    logic [2:0][3:0][7:0] zd;
    logic [3:0]           cand;
    logic                 hot;
    logic                 fixed_full;
    logic                 fixed_off;
    logic                 manual;
    logic [1:0]           pick;
    logic [7:0]           best;
    logic [7:0]           target;
    logic signed [9:0]    release_at;
    logic                 wr_ok;

    always_comb begin
        next_st    = st;
        cand       = 4'h0;
        hot        = 1'b0;
        fixed_full = 1'b0;
        fixed_off  = 1'b0;
        manual     = 1'b0;
        pick       = 2'd0;
        best       = 8'h00;
        target     = 8'h00;
        release_at = 10'sd0;
        zd         = '0;
        wr_ok      = reg_wr_in && !lock_in;

        // ----------------------------------------
        // ms tick divider
        // ----------------------------------------
        next_st.tick = 1'b0;
        if (st.tick_cnt >= 16'(TICK_CYCLES - 1)) begin
            next_st.tick_cnt = 16'h0000;
            next_st.tick     = 1'b1;
        end else begin
            next_st.tick_cnt = st.tick_cnt + 16'h0001;
        end

        // ----------------------------------------
        // pwm period counter, 255 steps so FFh never drops low
        // ----------------------------------------
        if (st.pwm_cnt >= `FZ_PWM_TOP) begin
            next_st.pwm_cnt = 8'h00;
        end else begin
            next_st.pwm_cnt = st.pwm_cnt + 8'h01;
        end

        // ----------------------------------------
        // absolute-maximum override per zone
        // ----------------------------------------
        for (int z = 0; z < 4; z++) begin
            release_at = 10'(zone_abs_limit_in[z]) - 10'(signed'({1'b0, zone_hyst_in[z]}));
            if (zone_abs_limit_in[z] == `FZ_ABS_OFF) begin
                next_st.over[z] = 1'b0;
            end else if (ztemp[z] > zone_abs_limit_in[z]) begin
                next_st.over[z] = 1'b1;
            end else if (10'(ztemp[z]) < release_at) begin
                next_st.over[z] = 1'b0;
            end
        end

        for (int f = 0; f < 3; f++) begin
            for (int z = 0; z < 4; z++) begin
                zd[f][z] = zone_duty(ztemp[z], st.lim[z], st.floor[f], floor_sel[f]);
            end
            cand       = 4'h0;
            hot        = 1'b0;
            fixed_full = 1'b0;
            fixed_off  = 1'b0;
            manual     = 1'b0;
            if (st.cfg[f].alt) begin
                unique case (st.cfg[f].mode)
                    FZ_M_Z1: cand = 4'h8;
                    FZ_M_Z2: begin
                        cand = 4'hf;
                        hot  = 1'b1;
                    end
                    default: fixed_full = 1'b1;
                endcase
            end else begin
                unique case (st.cfg[f].mode)
                    FZ_M_Z1:     cand = 4'h1;
                    FZ_M_Z2:     cand = 4'h2;
                    FZ_M_Z3:     cand = 4'h4;
                    FZ_M_FULL:   fixed_full = 1'b1;
                    FZ_M_OFF:    fixed_off = 1'b1;
                    FZ_M_HOT23: begin
                        cand = 4'h6;
                        hot  = 1'b1;
                    end
                    FZ_M_HOT123: begin
                        cand = 4'h7;
                        hot  = 1'b1;
                    end
                    FZ_M_MANUAL: manual = 1'b1;
                endcase
            end

            // ----------------------------------------
            // choose zone by larger computed duty
            // ----------------------------------------
            pick = 2'd0;
            best = 8'h00;
            for (int z = 0; z < 4; z++) begin
                if (cand[z] && (best == 8'h00 || zd[f][z] > best)) begin
                    best = zd[f][z];
                    pick = 2'(z);
                end
            end

            if (fixed_full) begin
                target = `FZ_DUTY_FULL;
            end else if (fixed_off) begin
                target = 8'h00;
            end else if (manual) begin
                target = manual_duty_in[f];
            end else if (st.over[pick]) begin
                target = `FZ_DUTY_FULL;
            end else if (best > st.ceil[f]) begin
                target = st.ceil[f];
            end else begin
                target = best;
            end
            next_st.duty[f] = target;

            // ----------------------------------------
            // zone report: hottest modes only
            // ----------------------------------------
            next_st.report[2*f+2 +: 2] = hot ? 2'(pick + 2'd1) : 2'b00;

            // ----------------------------------------
            // spin-up from standstill
            // ----------------------------------------
            next_st.running[f] = (target != 8'h00);
            if (target != 8'h00 && !st.running[f]) begin
                next_st.spin_cnt[f] = spin_ms(st.cfg[f].spin);
            end else if (target == 8'h00) begin
                next_st.spin_cnt[f] = 12'h000;
            end else if (st.tick && st.spin_cnt[f] != 12'h000) begin
                next_st.spin_cnt[f] = st.spin_cnt[f] - 12'h001;
            end

            // ----------------------------------------
            // output compare then polarity
            // ----------------------------------------
            if (st.spin_cnt[f] != 12'h000) begin
                next_st.pwm[f] = 1'b1 ^ st.cfg[f].pwm_polarity_invert;
            end else begin
                next_st.pwm[f] = (st.pwm_cnt < st.duty[f]) ^ st.cfg[f].pwm_polarity_invert;
            end
        end
        next_st.report[1:0] = 2'b00;

        // ----------------------------------------
        // register writes; report offset has no write path
        // ----------------------------------------
        if (wr_ok) begin
            unique case (reg_addr_in)
                `FZ_A_CEIL1:  next_st.ceil[0]  = reg_wdata_in;
                `FZ_A_CEIL2:  next_st.ceil[1]  = reg_wdata_in;
                `FZ_A_CEIL3:  next_st.ceil[2]  = reg_wdata_in;
                `FZ_A_LIM4:   next_st.lim[3]   = reg_wdata_in;
                `FZ_A_R3C:    next_st.r3c      = reg_wdata_in;
                `FZ_A_CFG1:   next_st.cfg[0]   = reg_wdata_in;
                `FZ_A_CFG2:   next_st.cfg[1]   = reg_wdata_in;
                `FZ_A_CFG3:   next_st.cfg[2]   = reg_wdata_in;
                `FZ_A_R62:    next_st.r62      = {reg_wdata_in[7:5], 1'b0, reg_wdata_in[3:0]};
                `FZ_A_R63:    next_st.r63      = reg_wdata_in;
                `FZ_A_FLOOR1: next_st.floor[0] = reg_wdata_in;
                `FZ_A_FLOOR2: next_st.floor[1] = reg_wdata_in;
                `FZ_A_FLOOR3: next_st.floor[2] = reg_wdata_in;
                `FZ_A_LIM1:   next_st.lim[0]   = reg_wdata_in;
                `FZ_A_LIM2:   next_st.lim[1]   = reg_wdata_in;
                `FZ_A_LIM3:   next_st.lim[2]   = reg_wdata_in;
                default: ;
            endcase
        end

        // ----------------------------------------
        // registered read data
        // ----------------------------------------
        unique case (reg_addr_in)
            `FZ_A_REPORT: next_st.rdata = st.report;
            `FZ_A_CEIL1:  next_st.rdata = st.ceil[0];
            `FZ_A_CEIL2:  next_st.rdata = st.ceil[1];
            `FZ_A_CEIL3:  next_st.rdata = st.ceil[2];
            `FZ_A_LIM4:   next_st.rdata = st.lim[3];
            `FZ_A_R3C:    next_st.rdata = st.r3c;
            `FZ_A_CFG1:   next_st.rdata = st.cfg[0];
            `FZ_A_CFG2:   next_st.rdata = st.cfg[1];
            `FZ_A_CFG3:   next_st.rdata = st.cfg[2];
            `FZ_A_R62:    next_st.rdata = st.r62;
            `FZ_A_R63:    next_st.rdata = st.r63;
            `FZ_A_FLOOR1: next_st.rdata = st.floor[0];
            `FZ_A_FLOOR2: next_st.rdata = st.floor[1];
            `FZ_A_FLOOR3: next_st.rdata = st.floor[2];
            `FZ_A_LIM1:   next_st.rdata = st.lim[0];
            `FZ_A_LIM2:   next_st.rdata = st.lim[1];
            `FZ_A_LIM3:   next_st.rdata = st.lim[2];
            default:      next_st.rdata = 8'h00;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            st          <= '0;
            st.cfg      <= {3{`FZ_RST_CFG}};
            st.ceil     <= {3{`FZ_RST_CEIL}};
            st.floor    <= {3{`FZ_RST_FLOOR}};
            st.lim      <= {`FZ_RST_LIM4, {3{`FZ_RST_LIM}}};
            st.r62      <= `FZ_RST_R62;
            st.r63      <= `FZ_RST_R63;
            st.r3c      <= `FZ_RST_R3C;
        end else begin
            st <= next_st;
        end
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign reg_rdata_out      = st.rdata;
    assign pwm_out            = st.pwm;
    assign fan_duty_out       = st.duty;
    assign zone_ctrl_temp_out = ztemp;
endmodule // fz_fan_ctrl

// [tb/fz_fan_ctrl_props.sv]
`timescale 1ns/1ps
// ----------------
// port checker
// ----------------
module fz_fan_ctrl_props
    import fz_pkg::*;
(
    input wire logic            core_clk_in,
    input wire logic            nrst_in,
    input wire logic [7:0]      reg_addr_in,
    input wire logic            reg_wr_in,
    input wire logic [7:0]      reg_wdata_in,
    input wire logic            lock_in,
    input wire logic [7:0]      reg_rdata_out,
    input wire logic [2:0]      pwm_out,
    input wire logic [2:0][7:0] fan_duty_out
);
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_unmapped;
        reg_addr_in == 8'h10 |=> reg_rdata_out == 8'h00;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_report_rsv;
        reg_addr_in == 8'h00 |=> reg_rdata_out[1:0] == 2'b00;
    endproperty
    a_report_rsv: assert property (p_report_rsv) else $error("report low bits set");
    property p_lock_hold;
        ($stable(reg_addr_in) && lock_in && reg_addr_in != 8'h00) [*2] |=> $stable(reg_rdata_out);
    endproperty
    a_lock_hold: assert property (p_lock_hold) else $error("locked register changed");
    property p_write_seen;
        reg_wr_in && !lock_in && reg_addr_in == 8'h67 ##1 reg_addr_in == 8'h67 && !reg_wr_in
            |=> reg_rdata_out == $past(reg_wdata_in, 2);
    endproperty
    a_write_seen: assert property (p_write_seen) else $error("limit write lost");
    property p_full0;
        (fan_duty_out[0] == 8'hff && !reg_wr_in) [*3] |=> $stable(pwm_out[0]);
    endproperty
    a_full0: assert property (p_full0) else $error("fan1 full duty toggles");
    property p_full2;
        (fan_duty_out[2] == 8'hff && !reg_wr_in) [*3] |=> $stable(pwm_out[2]);
    endproperty
    a_full2: assert property (p_full2) else $error("fan3 full duty toggles");
    property p_zero0;
        (fan_duty_out[0] == 8'h00 && !reg_wr_in) [*3] |=> $stable(pwm_out[0]);
    endproperty
    a_zero0: assert property (p_zero0) else $error("fan1 zero duty toggles");
    property p_zero1;
        (fan_duty_out[1] == 8'h00 && !reg_wr_in) [*3] |=> !pwm_out[1] || $stable(pwm_out[1]);
    endproperty
    a_zero1: assert property (p_zero1) else $error("fan2 zero duty toggles");
    c_full: cover property (fan_duty_out[0] == 8'hff);
    c_lock: cover property (reg_wr_in && lock_in);
    c_pwm: cover property ($rose(pwm_out[0]));
endmodule // fz_fan_ctrl_props

bind fz_fan_ctrl fz_fan_ctrl_props u_fz_fan_ctrl_props (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .reg_addr_in(reg_addr_in),
    .reg_wr_in(reg_wr_in), .reg_wdata_in(reg_wdata_in), .lock_in(lock_in),
    .reg_rdata_out(reg_rdata_out), .pwm_out(pwm_out), .fan_duty_out(fan_duty_out)
);

// [tb/fz_fan_drive.sv]
`timescale 1ns/1ps
// ----------------
// fan drive model: counts high cycles per output
// ----------------
module fz_fan_drive (
    input  wire logic        core_clk_in,
    input  wire logic        clr_in,
    input  wire logic [2:0]  pwm_in,
    output logic [2:0][15:0] hi_out
);
    always_ff @(posedge core_clk_in) begin
        for (int i = 0; i < 3; i++) begin
            hi_out[i] <= clr_in ? 16'h0000 : hi_out[i] + 16'(pwm_in[i]);
        end
    end
endmodule // fz_fan_drive

// [tb/fz_fan_ctrl_tb.sv]
`timescale 1ns/1ps
module fz_fan_ctrl_tb
    import fz_pkg::*;
;
    logic            clk, nrst, wr, lock, clr;
    logic [7:0]      addr, wd, rdata;
    fz_temp_t [3:0]  zt, za, ct;
    logic [3:0][3:0] zh;
    logic [2:0][7:0] md, duty;
    logic [2:0]      pwm;
    logic [2:0][15:0] hi;
    int              n_errors, num_checks;
    localparam logic [7:0] RA [18] = '{8'h38, 8'h39, 8'h3a, 8'h3b, 8'h3c, 8'h62, 8'h63, 8'h64,
        8'h65, 8'h66, 8'h67, 8'h68, 8'h69, 8'h5c, 8'h5d, 8'h5e, 8'h10, 8'h00};
    localparam logic [7:0] RV [18] = '{8'hff, 8'hff, 8'hff, 8'he0, 8'hc3, 8'h00, 8'h00, 8'h80,
        8'h80, 8'h80, 8'h5a, 8'h5a, 8'h5a, 8'h62, 8'h62, 8'h62, 8'h00, 8'h00};
    fz_fan_ctrl #(.TICK_CYCLES(25)) u_fz_fan_ctrl (
        .core_clk_in(clk), .nrst_in(nrst), .reg_addr_in(addr), .reg_wr_in(wr),
        .reg_wdata_in(wd), .lock_in(lock), .zone_temp_in(zt), .zone_abs_limit_in(za),
        .zone_hyst_in(zh), .manual_duty_in(md), .reg_rdata_out(rdata), .pwm_out(pwm),
        .fan_duty_out(duty), .zone_ctrl_temp_out(ct));
    fz_fan_drive u_fz_fan_drive (.core_clk_in(clk), .clr_in(clr), .pwm_in(pwm), .hi_out(hi));
    // ----------------
    // shared tasks
    // ----------------
    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk); #2 addr = a; wd = d; wr = 1'b1;
        @(posedge clk); #2 wr = 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk); #2 addr = a;
        @(posedge clk); #1 check(16'(rdata), 16'(e));
    endtask
    task automatic wait_duty(input int f, input logic [7:0] e);
        int k;
        for (k = 0; k < 40 && duty[f] !== e; k++) begin
            @(posedge clk);
            #1;
        end
        check(16'(duty[f]), 16'(e));
        if (k == 40) test_done();
    endtask
    task automatic temp(input int z, input logic [7:0] v, input int f, input logic [7:0] e);
        @(posedge clk); #2 zt[z] = v;
        repeat (4) @(posedge clk);
        #1 wait_duty(f, e);
    endtask
    task automatic meas(input int f, input int n, input logic [15:0] e);
        @(posedge clk); #2 clr = 1'b1;
        @(posedge clk); #2 clr = 1'b0;
        repeat (n) @(posedge clk);
        #1 check(hi[f], e);
    endtask
    // ----------------
    // scenarios
    // ----------------
    task automatic t_reset();
        for (int i = 0; i < 18; i++) rreg(RA[i], RV[i]);
    endtask
    task automatic t_lock();
        @(posedge clk); #2 lock = 1'b1;
        wreg(8'h67, 8'h11);
        rreg(8'h67, 8'h5a);
        @(posedge clk); #2 lock = 1'b0;
        wreg(8'h00, 8'hff);
        rreg(8'h00, 8'h00);
    endtask
    task automatic t_zone();
        wreg(8'h5c, 8'h00);
        wreg(8'h67, 8'h28);
        wait_duty(0, 8'h00);
        wreg(8'h62, 8'h20);
        wait_duty(0, 8'h80);
        temp(0, 8'h28, 0, 8'h80);
        temp(0, 8'h2a, 0, 8'ha0);
        wreg(8'h38, 8'h90);
        wait_duty(0, 8'h90);
        temp(0, 8'h51, 0, 8'hff);
        temp(0, 8'h4d, 0, 8'hff);
        temp(0, 8'h4b, 0, 8'h90);
        @(posedge clk); #2 za[0] = 8'h80;
        temp(0, 8'h51, 0, 8'h90);
        @(posedge clk); #2 za[0] = 8'h50;
        wreg(8'h38, 8'hff);
        temp(0, 8'h2a, 0, 8'ha0);
    endtask
    task automatic t_hot();
        wreg(8'h68, 8'h28);
        wreg(8'h69, 8'h30);
        wreg(8'h5e, 8'he0);
        wreg(8'h5d, 8'ha0);
        @(posedge clk); #2 zt[2] = 8'h2e;
        temp(1, 8'h2c, 1, 8'hc0);
        wait_duty(2, 8'h40);
        rreg(8'h00, 8'h20);
        temp(2, 8'h36, 1, 8'he0);
        rreg(8'h00, 8'h30);
        wreg(8'h5e, 8'hc0);
        wait_duty(2, 8'he0);
        rreg(8'h00, 8'hf0);
        wreg(8'h5e, 8'h28);
        wait_duty(2, 8'hff);
        rreg(8'h00, 8'h30);
        wreg(8'h5e, 8'h80);
        wait_duty(2, 8'h00);
        rreg(8'h00, 8'h30);
    endtask
    task automatic t_pwm();
        wreg(8'h5e, 8'h60);
        meas(2, 255, 16'd255);
        wreg(8'h5e, 8'h70);
        meas(2, 255, 16'd0);
        meas(0, 255, 16'd160);
    endtask
    task automatic t_spin();
        int ms [3] = '{0, 100, 250};
        wreg(8'h62, 8'h00);
        for (int s = 0; s < 3; s++) begin
            temp(0, 8'h20, 0, 8'h00);
            wreg(8'h5c, 8'(s));
            temp(0, 8'h2a, 0, 8'ha0);
            if (ms[s] > 0) meas(0, ms[s] * 25 - 100, 16'(ms[s] * 25 - 100));
            repeat (200) @(posedge clk);
            meas(0, 255, 16'd160);
        end
    endtask
    task automatic t_smooth();
        wreg(8'h62, 8'h0f);
        @(posedge clk); #2 zt[0] = 8'h4a;
        repeat (50) @(posedge clk);
        #1 check(16'(ct[0]), 16'(8'sh2a));
        check(16'(ct[1]), 16'(zt[1]));
        repeat (30000) @(posedge clk);
        #1 check(16'(ct[0] >= 8'sh46), 16'h0001);
        check(16'(duty[0]), 16'h00ff);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        n_errors = 0;
        num_checks = 0;
        nrst = 1'b0;
        {wr, lock, clr, addr, wd} = '0;
        zt = {4{8'h20}};
        za = {4{8'h50}};
        zh = {4{4'h4}};
        md = {8'h40, 8'h00, 8'h00};
        repeat (3) @(posedge clk);
        #2 nrst = 1'b1;
        t_reset();
        t_lock();
        t_zone();
        t_hot();
        t_pwm();
        t_spin();
        t_smooth();
        test_done();
    end
endmodule // fz_fan_ctrl_tb
